// ==== hdl/dajx_core.sv ====
// What this block does
// - Decrement writes f minus one to the accumulator if d=0, else to f.
// - Decrement is one word and one cycle: decode, read, process, write.
// - The jump loads its 11-bit literal into program counter bits 10:0.
// - The jump takes two cycles, the second a no-op in all four phases.
// - The jump is coded 101 then the literal and leaves all flags alone.
`timescale 1ns/1ps
module dajx_core
  import dajx_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Instruction fetched for the current cycle, sampled at Q1.
  input wire logic [DAJX_IW-1:0] instr_in,
  // Program counter high latch.
  input wire logic [7:0] pc_high_latch_in,
  // Core state.
  output logic [DAJX_PCW-1:0] pc_out,
  output logic [7:0] acc_out,
  output logic zero_flag_out,
  output logic [1:0] phase_out,
  output logic flush_out,
  output logic illegal_out
);

  // Phase sequencer.
  dajx_phase_t phase_r;
  dajx_phase_t phase_nxt;

  // Instruction register.
  logic [DAJX_IW-1:0] ir_r;
  logic [DAJX_IW-1:0] ir_nxt;

  // Result of the process phase.
  logic [7:0] res_r;
  logic [7:0] res_nxt;

  // Program flow.
  logic [DAJX_PCW-1:0] pc_r;
  logic [DAJX_PCW-1:0] pc_nxt;
  logic flush_r;
  logic flush_nxt;

  // Accumulator, zero flag and register file write request.
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic zero_r;
  logic zero_nxt;
  dajx_fwr_t fwr;

  // Marker for a word that is neither operation.
  logic illegal_r;
  logic illegal_nxt;

  // Fields of the held word.
  logic [7:0] rd_data;
  logic is_dec;
  logic is_jmp;
  logic dbit;
  logic [DAJX_FW-1:0] faddr;
  logic [DAJX_LITW-1:0] lit;
  logic [1:0] pc_hi;
  logic at_q4;
  logic live_q4;

  always_comb begin
    is_dec = (ir_r[13:12] == DAJX_PFX_BYTE) &&
             (ir_r[11:8] == DAJX_OPC_DEC);
    is_jmp = (ir_r[13:11] == DAJX_OPC_JMP);
    dbit = ir_r[DAJX_DBIT_POS];
    faddr = ir_r[DAJX_FW-1:0];
    lit = ir_r[DAJX_LITW-1:0];
    pc_hi = pc_high_latch_in[DAJX_LATCH_LO_POS+1:
                             DAJX_LATCH_LO_POS];
    at_q4 = (phase_r == DAJX_Q4);
    // The dead slot after a jump is a Q4 that must not execute.
    live_q4 = at_q4 && !flush_r;
  end

  dajx_regfile #(
    .AW(DAJX_FW)
  ) dajx_regfile_inst (
    .clk_sys_in(clk_sys_in),
    .rd_addr_in(faddr),
    .rd_data_out(rd_data),
    .wr_in(fwr)
  );

  // Q1 decode, Q2 read, Q3 process, Q4 write, then round again.
  always_comb begin
    case (phase_r)
      DAJX_Q1: begin
        phase_nxt = DAJX_Q2;
      end
      DAJX_Q2: begin
        phase_nxt = DAJX_Q3;
      end
      DAJX_Q3: begin
        phase_nxt = DAJX_Q4;
      end
      DAJX_Q4: begin
        phase_nxt = DAJX_Q1;
      end
      default: begin
        phase_nxt = DAJX_Q1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      phase_r <= DAJX_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // The word is taken at the end of Q1. The dead slot after a jump takes
  // an all-zero word instead, which decodes as neither operation.
  always_comb begin
    ir_nxt = ir_r;
    if (phase_r == DAJX_Q1) begin
      if (flush_r) begin
        ir_nxt = '0;
      end else begin
        ir_nxt = instr_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ir_r <= '0;
    end else begin
      ir_r <= ir_nxt;
    end
  end

  // The register file answers one edge after its address settles, so
  // its data are taken at the end of Q3.
  always_comb begin
    res_nxt = res_r;
    if (phase_r == DAJX_Q3) begin
      res_nxt = rd_data - 8'h01;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      res_r <= 8'h00;
    end else begin
      res_r <= res_nxt;
    end
  end

  // Q4 either steps the counter or loads the jump target; the dead
  // slot only clears the flush marker.
  always_comb begin
    pc_nxt = pc_r;
    flush_nxt = flush_r;
    if (at_q4) begin
      if (flush_r) begin
        flush_nxt = 1'h0;
      end else if (is_jmp) begin
        pc_nxt = {pc_hi, lit};
        flush_nxt = 1'h1;
      end else begin
        pc_nxt = pc_r + 13'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pc_r <= DAJX_PC_RST;
      flush_r <= 1'h0;
    end else begin
      pc_r <= pc_nxt;
      flush_r <= flush_nxt;
    end
  end

  // Only a live decrement touches the accumulator, the zero flag or the
  // register file, so a jump leaves the flag as it was.
  always_comb begin
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    fwr = '0;
    if (live_q4 && is_dec) begin
      zero_nxt = (res_r == 8'h00);
      if (dbit) begin
        fwr.we = 1'h1;
        fwr.addr = faddr;
        fwr.data = res_r;
      end else begin
        acc_nxt = res_r;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      acc_r <= DAJX_ACC_RST;
      zero_r <= 1'h0;
    end else begin
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
    end
  end

  // An unknown word still steps the counter; the marker then stands for
  // the whole of the next instruction cycle.
  always_comb begin
    illegal_nxt = illegal_r;
    if (at_q4) begin
      illegal_nxt = live_q4 && !is_dec && !is_jmp;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      illegal_r <= 1'h0;
    end else begin
      illegal_r <= illegal_nxt;
    end
  end

  assign pc_out = pc_r;
  assign acc_out = acc_r;
  assign zero_flag_out = zero_r;
  assign phase_out = phase_r;
  assign flush_out = flush_r;
  assign illegal_out = illegal_r;

endmodule : dajx_core

// ==== hdl/dajx_pkg.sv ====
package dajx_pkg;

  // Instruction word layout (14 bits).
  localparam int DAJX_IW = 14;
  localparam int DAJX_PCW = 13;
  localparam int DAJX_LITW = 11;
  localparam int DAJX_FW = 7;
  localparam logic [1:0] DAJX_PFX_BYTE = 2'h0;
  localparam logic [3:0] DAJX_OPC_DEC = 4'h3;
  localparam logic [2:0] DAJX_OPC_JMP = 3'h5;
  localparam int DAJX_DBIT_POS = 7;
  localparam int DAJX_LATCH_LO_POS = 3;
  localparam logic [7:0] DAJX_ACC_RST = 8'h00;
  localparam logic [DAJX_PCW-1:0] DAJX_PC_RST = 13'h0000;

  // Instruction cycle phases.
  typedef enum logic [1:0] {
    DAJX_Q1 = 2'b00,
    DAJX_Q2 = 2'b01,
    DAJX_Q3 = 2'b10,
    DAJX_Q4 = 2'b11
  } dajx_phase_t;

  // Register file write request.
  typedef struct packed {
    logic we;
    logic [DAJX_FW-1:0] addr;
    logic [7:0] data;
  } dajx_fwr_t;

endpackage : dajx_pkg

// ==== hdl/dajx_regfile.sv ====
`timescale 1ns/1ps
module dajx_regfile
  import dajx_pkg::*;
#(
  parameter int AW = DAJX_FW
) (
  // Clock, no reset.
  input wire logic clk_sys_in,
  // Read port.
  input wire logic [AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  // Write port.
  input wire dajx_fwr_t wr_in
);

  logic [7:0] mem_r [0:(1<<AW)-1];
  logic [7:0] rd_data_r;

  always_ff @(posedge clk_sys_in) begin
    if (wr_in.we) begin
      mem_r[wr_in.addr[AW-1:0]] <= wr_in.data;
    end
    rd_data_r <= mem_r[rd_addr_in];
  end

  assign rd_data_out = rd_data_r;

endmodule : dajx_regfile

// ==== tb/dajx_core_bench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module dajx_core_bench;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] latch = 8'h18;
  logic [13:0] instr;
  logic [12:0] pc;
  logic flush;
  logic illegal;
  logic [7:0] acc;
  logic zero;
  logic [1:0] phase;
  int miscompares = 0;
  int check_count = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  dajx_core dajx_core_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .instr_in(instr), .pc_high_latch_in(latch), .pc_out(pc), .acc_out(acc),
    .zero_flag_out(zero), .phase_out(phase), .flush_out(flush),
    .illegal_out(illegal));
  dajx_prog_mem dajx_prog_mem_inst (.pc_in(pc), .instr_out(instr));
  task tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick
  task test_dec;
    tick(5);
    `CHK(pc, 13'h0001)
    `CHK(phase, 2'h1)
    `CHK(acc, 8'h00)
    `CHK(zero, 1'h1)
    `CHK(illegal, 1'h0)
    $display("test_dec done");
  endtask : test_dec
  task test_jump;
    tick(4);
    `CHK(pc, 13'h1ffe)
    `CHK(flush, 1'h1)
    `CHK(zero, 1'h1)
    tick(4);
    `CHK(pc, 13'h1ffe)
    `CHK(flush, 1'h0)
    $display("test_jump done");
  endtask : test_jump
  task test_wrap;
    tick(4);
    `CHK(pc, 13'h1fff)
    `CHK(acc, 8'hff)
    `CHK(zero, 1'h0)
    `CHK(illegal, 1'h0)
    tick(4);
    `CHK(pc, 13'h0000)
    `CHK(flush, 1'h0)
    `CHK(illegal, 1'h1)
    `CHK(acc, 8'hff)
    $display("test_wrap done");
  endtask : test_wrap
  task results;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  initial begin
    // Register 5 starts at one so that the first decrement reaches zero.
    dajx_core_inst.dajx_regfile_inst.mem_r[5] = 8'h01;
    dajx_prog_mem_inst.mem[0] = 14'h0385;
    dajx_prog_mem_inst.mem[1] = 14'h2ffe;
    dajx_prog_mem_inst.mem[13'h1ffe] = 14'h0305;
    // Prefix 10 with bit 11 clear is not a jump and must step the counter.
    dajx_prog_mem_inst.mem[13'h1fff] = 14'h27ff;
    repeat (20) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    test_dec;
    test_jump;
    test_wrap;
    results;
  end
endmodule : dajx_core_bench

// ==== tb/dajx_core_props.sv ====
`timescale 1ns/1ps
module dajx_core_props
  import dajx_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [DAJX_IW-1:0] instr_in,
  input wire logic [7:0] pc_high_latch_in,
  input wire logic [DAJX_PCW-1:0] pc_out,
  input wire logic [7:0] acc_out,
  input wire logic zero_flag_out,
  input wire logic [1:0] phase_out,
  input wire logic flush_out,
  input wire logic illegal_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic tk;
  assign tk = phase_out == 2'h0 && !flush_out;
  sequence s_jmp;
    tk && instr_in[13:11] == DAJX_OPC_JMP;
  endsequence
  sequence s_dec;
    tk && instr_in[13:8] == {DAJX_PFX_BYTE, DAJX_OPC_DEC};
  endsequence
  AST_PHASE_STEP: assert property (phase_out != 2'h3 |=>
    phase_out == $past(phase_out) + 2'h1) else $error("phase skipped");
  AST_JMP_LIT: assert property (s_jmp |-> ##4
    pc_out[10:0] == $past(instr_in[10:0], 4)) else $error("bad literal");
  AST_JMP_HI: assert property (s_jmp |-> ##4
    pc_out[12:11] == $past(pc_high_latch_in[4:3])) else $error("bad high");
  AST_JMP_FLUSH: assert property (s_jmp |-> ##4
    flush_out [*4] ##1 !flush_out) else $error("bad no-op cycle");
  AST_FLUSH_HOLD: assert property (flush_out && $past(flush_out) |->
    $stable(pc_out) && $stable(acc_out)) else $error("state moved");
  AST_JMP_FLAGS: assert property (s_jmp |-> ##4
    $stable(zero_flag_out)) else $error("jump touched flag");
  AST_DEC_PC: assert property (s_dec |-> ##4 !illegal_out &&
    pc_out == $past(pc_out, 4) + 13'h1) else $error("bad step");
  AST_DEC_KEEP: assert property (s_dec ##0 instr_in[7] |-> ##4
    $stable(acc_out)) else $error("accumulator written");
  AST_DEC_ZERO: assert property (s_dec ##0 !instr_in[7] |-> ##4
    zero_flag_out == (acc_out == 8'h00)) else $error("bad zero flag");
  sequence s_near;
    tk && instr_in[13:12] == 2'h2 && !instr_in[11];
  endsequence
  AST_NOT_JMP: assert property (s_near |-> ##4 !flush_out &&
    pc_out == $past(pc_out, 4) + 13'h1) else $error("false jump");
endmodule : dajx_core_props
bind dajx_core dajx_core_props dajx_core_props_inst (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .instr_in(instr_in),
  .pc_high_latch_in(pc_high_latch_in), .pc_out(pc_out), .acc_out(acc_out),
  .zero_flag_out(zero_flag_out), .phase_out(phase_out),
  .flush_out(flush_out), .illegal_out(illegal_out));

// ==== tb/dajx_prog_mem.sv ====
`timescale 1ns/1ps
module dajx_prog_mem
  import dajx_pkg::*;
(
  // Fetch port.
  input wire logic [DAJX_PCW-1:0] pc_in,
  output logic [DAJX_IW-1:0] instr_out
);
  logic [DAJX_IW-1:0] mem [0:8191];
  // The store answers at once, so a fetch never stalls the core.
  assign instr_out = mem[pc_in];
endmodule : dajx_prog_mem
